// File: design/rac_params.svh
// constants for the regeneration avoidance control block
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH
// register offsets (word index on the plain register port)
`define RAC_OFF_MODE        4'h0
`define RAC_OFF_LEVEL       4'h1
`define RAC_OFF_LIMIT       4'h2
`define RAC_OFF_VGAIN       4'h3
`define RAC_OFF_FGAIN       4'h4
`define RAC_OFF_DISP_SEL    4'h5
`define RAC_OFF_STALL_SEL   4'h6
`define RAC_OFF_STALL_TMR   4'h7
`define RAC_OFF_MAX_FREQ    4'h8
`define RAC_OFF_IRQ_STATUS  4'h9
`define RAC_OFF_IRQ_MASK    4'ha
`define RAC_OFF_STATE       4'hb
`define RAC_OFF_OUT_FREQ    4'hc
// mode encodings
`define RAC_MODE_OFF        16'h0000
`define RAC_MODE_ALWAYS     16'h0001
`define RAC_MODE_CONST      16'h0002
// level in volts, frequencies in 0.01 Hz, gains in percent
`define RAC_LEVEL_MIN       16'h012c
`define RAC_LEVEL_MAX       16'h0320
`define RAC_LEVEL_RST_LOW   16'h0190
`define RAC_LEVEL_RST_HIGH  16'h030c
`define RAC_LIMIT_MAX       16'h03e8
`define RAC_LIMIT_RST       16'h0258
`define RAC_LIMIT_NONE      16'h270f
`define RAC_GAIN_MAX        16'h00c8
`define RAC_GAIN_RST        16'h0064
`define RAC_MAX_FREQ_RST    16'h2710
`define RAC_STALL_TMR_RST   16'h0000
// interrupt status bits
`define RAC_IRQ_START_BIT   0
`define RAC_IRQ_END_BIT     1
`define RAC_IRQ_CLAMP_BIT   2
`define RAC_IRQ_WIDTH       3
// timer tick: 100 ms of stall timer unit at 100 MHz clock
`define RAC_CLK_HZ          100000000
`define RAC_TICK_MS         100
`define RAC_TICK_CYCLES     ((`RAC_CLK_HZ / 1000) * `RAC_TICK_MS)
`endif

// File: design/rac_pkg.sv
// types for the regeneration avoidance control block
package rac_pkg;
   typedef enum logic [1:0] {RAC_IDLE, RAC_RAISE, RAC_HOLD} rac_state_t;
   typedef enum logic [1:0] {RAC_ACC, RAC_CONST, RAC_DEC} rac_motion_t;
endpackage

// File: design/rac_slope.sv
// compensation slope from bus excess, voltage gain and frequency gain
module rac_slope
  #(parameter int W = 16)
   (input wire logic [W-1:0] excess_in,
    input wire logic [W-1:0] vgain_in,
    input wire logic [W-1:0] fgain_in,
    output logic [W-1:0] step_out);
   logic [3*W-1:0] prod;
   logic [3*W-1:0] scaled;
   // steeper with larger overshoot; both gains at 100 % give excess/8 per update
   always_comb
   begin
      prod = {{(2*W){1'b0}}, excess_in} * {{(2*W){1'b0}}, vgain_in} * {{(2*W){1'b0}}, fgain_in};
      scaled = prod / (3*W)'(80000);
      step_out = (scaled > (3*W)'({W{1'b1}})) ? {W{1'b1}} : scaled[W-1:0];
   end
endmodule // rac_slope

// File: design/rac_stall_timer.sv
// stall output delay timer: raises the stall output after a programmed time
`include "rac_params.svh"
module rac_stall_timer
  #(parameter int TICK = `RAC_TICK_CYCLES)
   (input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    input wire logic [15:0] hold_in,
    output logic stall_out);
   typedef struct packed
   {
      logic [31:0] tick;
      logic [15:0] cnt;
      logic out;
   } rac_tmr_t;
   rac_tmr_t q_ff;
   rac_tmr_t nxt_q;
   always_comb
   begin
      nxt_q = q_ff;
      if (!stall_in)
      begin
         nxt_q.tick = '0;
         nxt_q.cnt = '0;
         nxt_q.out = 1'b0;
      end
      else if (q_ff.cnt >= hold_in)
         nxt_q.out = 1'b1;
      else if (q_ff.tick == 32'(TICK - 1))
      begin
         nxt_q.tick = '0;
         nxt_q.cnt = q_ff.cnt + 16'h0001;
      end
      else
         nxt_q.tick = q_ff.tick + 32'h0000_0001;
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         q_ff <= '0;
      else
         q_ff <= nxt_q;
   end
   assign stall_out = q_ff.out;
endmodule // rac_stall_timer

// File: design/rac_core.sv
// regeneration avoidance control: registers, compensation and stall outputs
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "rac_params.svh"

// Summary of operation
// - mode 0 disables, 1 always active, 2 starts only at constant speed, then stays on in any motion.
// - bus voltage at or above level raises output frequency.
// - operation level 300..800 V; default 400 V or 780 V by class.
// - accel/constant: raised frequency capped at base plus limit (0..10 Hz, 6).
// - decel: limit held until base frequency falls to half the limit.
// - raised frequency clamped at maximum output frequency.
// - limit value 9999 removes the cap.
// - voltage gain 0..200 %, default 100, scales response.
// - frequency gain 0..200 % also scales the response.
// - while active, show overvoltage stall; drive stall output after its timer when stall select bit 0 is set.
// - stall prevention active together with avoidance.
// - decel overvoltage stall keeps avoidance active, raising with regeneration.
// - raise slope varies with regeneration severity; fall is 1 per update once the bus is below level.
// - parameter writes accepted only when display select is 0.
module rac_core
  #(parameter bit HIGH_CLASS = 1'b0,
    parameter int TICK = `RAC_TICK_CYCLES)
   (input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [15:0] bus_voltage_in,
    input wire logic [15:0] base_freq_in,
    input wire logic accel_in,
    input wire logic decel_in,
    output logic [15:0] out_freq_out,
    output logic avoidance_active_out,
    output logic overvoltage_stall_indication_out,
    output logic stall_prevention_out,
    output logic stall_output_signal_out,
    output logic irq_out);

   typedef struct packed
   {
      logic [15:0] mode;
      logic [15:0] level;
      logic [15:0] limit;
      logic [15:0] vgain;
      logic [15:0] fgain;
      logic [15:0] disp_sel;
      logic [15:0] stall_sel;
      logic [15:0] stall_tmr;
      logic [15:0] max_freq;
      logic [`RAC_IRQ_WIDTH-1:0] irq_status;
      logic [`RAC_IRQ_WIDTH-1:0] irq_mask;
      logic [15:0] comp;
      logic [15:0] out_freq;
      logic held;
      logic clamped;
      rac_pkg::rac_state_t state;
      logic [15:0] rdata;
   } rac_core_t;

   rac_core_t q_ff;
   rac_core_t nxt_q;
   logic [15:0] step;
   logic [15:0] excess;
   logic stall_timed;
   rac_pkg::rac_motion_t motion;

   // clip helper used for level, limit and gain writes
   function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   assign motion = decel_in ? rac_pkg::RAC_DEC : (accel_in ? rac_pkg::RAC_ACC : rac_pkg::RAC_CONST);
   assign excess = (bus_voltage_in > q_ff.level) ? (bus_voltage_in - q_ff.level) : 16'h0000;

   rac_slope #(.W(16)) u_slope
   (
      .excess_in(excess),
      .vgain_in(q_ff.vgain),
      .fgain_in(q_ff.fgain),
      .step_out(step)
   );

   // ---------------------------------------------------------------
   // main next-state logic
   // ---------------------------------------------------------------
   logic enabled;
   logic over;
   logic [16:0] cap;
   logic [16:0] raised;
   logic [16:0] fmax;
   logic [15:0] dec_step;
   logic [`RAC_IRQ_WIDTH-1:0] ev;

   always_comb
   begin
      nxt_q = q_ff;
      ev = '0;
      over = (bus_voltage_in >= q_ff.level);
      // stalled deceleration keeps avoidance on regardless of mode 2
      unique case (q_ff.mode)
         `RAC_MODE_ALWAYS: enabled = 1'b1;
         `RAC_MODE_CONST: enabled = (motion == rac_pkg::RAC_CONST) || (q_ff.state != rac_pkg::RAC_IDLE);
         default: enabled = 1'b0;
      endcase
      // step grows with the overshoot; floor of 1 lets small excess still move
      dec_step = (step == 16'h0000) ? 16'h0001 : step;
      raised = {1'b0, q_ff.comp};
      if (enabled && over)
         raised = {1'b0, q_ff.comp} + {1'b0, dec_step};
      else if (q_ff.comp > dec_step)
         raised = {1'b0, q_ff.comp - dec_step};
      else
         raised = 17'h0_0000;
      // cap on added frequency
      cap = 17'h1_ffff;
      if (q_ff.limit != `RAC_LIMIT_NONE)
         cap = {1'b0, q_ff.limit};
      nxt_q.held = q_ff.held;
      if (motion == rac_pkg::RAC_DEC && enabled && over && raised >= cap)
         nxt_q.held = 1'b1;
      // judged on the pre-avoidance frequency: the held output never falls that low
      if (q_ff.held && (base_freq_in <= (q_ff.limit >> 1) || motion != rac_pkg::RAC_DEC))
         nxt_q.held = 1'b0;
      if (raised > cap || nxt_q.held)
         raised = (q_ff.limit == `RAC_LIMIT_NONE) ? raised : cap;
      // clamp at maximum output frequency
      fmax = {1'b0, q_ff.max_freq};
      nxt_q.clamped = 1'b0;
      if ({1'b0, base_freq_in} + raised >= fmax)
      begin
         nxt_q.clamped = 1'b1;
         raised = (fmax > {1'b0, base_freq_in}) ? fmax - {1'b0, base_freq_in} : 17'h0_0000;
      end
      nxt_q.comp = raised[15:0];
      nxt_q.out_freq = 16'(({1'b0, base_freq_in} + raised > fmax) ? fmax : {1'b0, base_freq_in} + raised);
      // state tracking
      unique case (q_ff.state)
         rac_pkg::RAC_IDLE:
            if (enabled && over)
            begin
               nxt_q.state = rac_pkg::RAC_RAISE;
               ev[`RAC_IRQ_START_BIT] = 1'b1;
            end
         rac_pkg::RAC_RAISE:
            if (nxt_q.held)
               nxt_q.state = rac_pkg::RAC_HOLD;
            else if (!over && nxt_q.comp == 16'h0000)
            begin
               nxt_q.state = rac_pkg::RAC_IDLE;
               ev[`RAC_IRQ_END_BIT] = 1'b1;
            end
         rac_pkg::RAC_HOLD:
            if (!nxt_q.held)
               nxt_q.state = rac_pkg::RAC_RAISE;
      endcase
      if (nxt_q.clamped && !q_ff.clamped)
         ev[`RAC_IRQ_CLAMP_BIT] = 1'b1;
      // register writes; all but display select and the interrupt registers gated by display select
      if (reg_wr_in)
      begin
         unique case (reg_addr_in)
            `RAC_OFF_DISP_SEL: nxt_q.disp_sel = reg_wdata_in;
            `RAC_OFF_IRQ_STATUS: nxt_q.irq_status = q_ff.irq_status & ~reg_wdata_in[`RAC_IRQ_WIDTH-1:0];
            `RAC_OFF_IRQ_MASK: nxt_q.irq_mask = reg_wdata_in[`RAC_IRQ_WIDTH-1:0];
            default:
               if (q_ff.disp_sel == 16'h0000)
               begin
                  unique case (reg_addr_in)
                     `RAC_OFF_MODE:
                        if (reg_wdata_in <= `RAC_MODE_CONST)
                           nxt_q.mode = reg_wdata_in;
                     `RAC_OFF_LEVEL: nxt_q.level = clip(reg_wdata_in, `RAC_LEVEL_MIN, `RAC_LEVEL_MAX);
                     `RAC_OFF_LIMIT:
                        nxt_q.limit = (reg_wdata_in == `RAC_LIMIT_NONE) ? reg_wdata_in
                                      : clip(reg_wdata_in, 16'h0000, `RAC_LIMIT_MAX);
                     `RAC_OFF_VGAIN: nxt_q.vgain = clip(reg_wdata_in, 16'h0000, `RAC_GAIN_MAX);
                     `RAC_OFF_FGAIN: nxt_q.fgain = clip(reg_wdata_in, 16'h0000, `RAC_GAIN_MAX);
                     `RAC_OFF_STALL_SEL: nxt_q.stall_sel = reg_wdata_in;
                     `RAC_OFF_STALL_TMR: nxt_q.stall_tmr = reg_wdata_in;
                     `RAC_OFF_MAX_FREQ: nxt_q.max_freq = reg_wdata_in;
                     default: ;
                  endcase
               end
         endcase
      end
      // set wins over write-one-to-clear
      nxt_q.irq_status = nxt_q.irq_status | ev;
      // read data, one cycle later
      nxt_q.rdata = 16'h0000;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            `RAC_OFF_MODE: nxt_q.rdata = q_ff.mode;
            `RAC_OFF_LEVEL: nxt_q.rdata = q_ff.level;
            `RAC_OFF_LIMIT: nxt_q.rdata = q_ff.limit;
            `RAC_OFF_VGAIN: nxt_q.rdata = q_ff.vgain;
            `RAC_OFF_FGAIN: nxt_q.rdata = q_ff.fgain;
            `RAC_OFF_DISP_SEL: nxt_q.rdata = q_ff.disp_sel;
            `RAC_OFF_STALL_SEL: nxt_q.rdata = q_ff.stall_sel;
            `RAC_OFF_STALL_TMR: nxt_q.rdata = q_ff.stall_tmr;
            `RAC_OFF_MAX_FREQ: nxt_q.rdata = q_ff.max_freq;
            `RAC_OFF_IRQ_STATUS: nxt_q.rdata = 16'(q_ff.irq_status);
            `RAC_OFF_IRQ_MASK: nxt_q.rdata = 16'(q_ff.irq_mask);
            `RAC_OFF_STATE: nxt_q.rdata = {12'h000, q_ff.clamped, q_ff.held, 2'(q_ff.state)};
            `RAC_OFF_OUT_FREQ: nxt_q.rdata = q_ff.out_freq;
            default: nxt_q.rdata = 16'h0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q_ff <= '0;
         q_ff.mode <= `RAC_MODE_OFF;
         q_ff.level <= HIGH_CLASS ? `RAC_LEVEL_RST_HIGH : `RAC_LEVEL_RST_LOW;
         q_ff.limit <= `RAC_LIMIT_RST;
         q_ff.vgain <= `RAC_GAIN_RST;
         q_ff.fgain <= `RAC_GAIN_RST;
         q_ff.stall_tmr <= `RAC_STALL_TMR_RST;
         q_ff.max_freq <= `RAC_MAX_FREQ_RST;
         q_ff.state <= rac_pkg::RAC_IDLE;
      end
      else
         q_ff <= nxt_q;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // stall output only when the select register enables it; timer delays it
   rac_stall_timer #(.TICK(TICK)) u_stall_timer
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .stall_in(avoidance_active_out && q_ff.stall_sel[0]),
      .hold_in(q_ff.stall_tmr),
      .stall_out(stall_timed)
   );

   assign avoidance_active_out = (q_ff.state != rac_pkg::RAC_IDLE);
   assign overvoltage_stall_indication_out = avoidance_active_out;
   assign stall_prevention_out = avoidance_active_out;
   assign stall_output_signal_out = stall_timed;
   assign out_freq_out = q_ff.out_freq;
   assign reg_rdata_out = q_ff.rdata;
   assign irq_out = |(q_ff.irq_status & q_ff.irq_mask);
endmodule // rac_core

// File: verification/rac_drive_model.sv
// far-side model: bus voltage measurement and frequency path of the drive
module rac_drive_model
   (input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] bus_cmd_in,
    input wire logic [15:0] base_cmd_in,
    input wire logic accel_cmd_in,
    input wire logic decel_cmd_in,
    output logic [15:0] bus_voltage_out,
    output logic [15:0] base_freq_out,
    output logic accel_out,
    output logic decel_out);
   timeunit 1ns;
   timeprecision 1ps;
   // measurement is sampled, so the block sees each change one cycle late
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bus_voltage_out <= 16'h0000;
         base_freq_out <= 16'h0000;
         accel_out <= 1'b0;
         decel_out <= 1'b0;
      end
      else
      begin
         bus_voltage_out <= bus_cmd_in;
         base_freq_out <= base_cmd_in;
         accel_out <= accel_cmd_in;
         decel_out <= decel_cmd_in;
      end
   end
endmodule // rac_drive_model

// File: verification/rac_monitor.sv
// port-level assertions for the regeneration avoidance block
module rac_monitor
   (input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [15:0] bus_voltage_in,
    input wire logic [15:0] base_freq_in,
    input wire logic [15:0] out_freq_out,
    input wire logic avoidance_active_out,
    input wire logic overvoltage_stall_indication_out,
    input wire logic stall_prevention_out,
    input wire logic stall_output_signal_out,
    input wire logic irq_out);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_indic; overvoltage_stall_indication_out == avoidance_active_out; endproperty
   a_indic: assert property (p_indic) else $error("stall indication differs from active");
   property p_prev; stall_prevention_out == avoidance_active_out; endproperty
   a_prev: assert property (p_prev) else $error("stall prevention differs from active");
   property p_stall_src; $rose(stall_output_signal_out) |-> $past(avoidance_active_out); endproperty
   a_stall_src: assert property (p_stall_src) else $error("stall output rose without avoidance");
   property p_rd_idle; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
   property p_start_level; $rose(avoidance_active_out) |-> $past(bus_voltage_in) >= 16'h012c; endproperty
   a_start_level: assert property (p_start_level) else $error("avoidance began below lowest level");
   property p_max; out_freq_out <= 16'h2710; endproperty
   a_max: assert property (p_max) else $error("output above maximum frequency");
   // compensation only grows while the bus stays at or above the highest level
   property p_raise;
      avoidance_active_out && $past(avoidance_active_out) && $past(bus_voltage_in) >= 16'h0320
      && $past(bus_voltage_in, 2) >= 16'h0320 && $past(base_freq_in) == $past(base_freq_in, 2)
      |-> out_freq_out >= $past(out_freq_out);
   endproperty
   a_raise: assert property (p_raise) else $error("output fell during overvoltage");
   property p_idle_freq;
      !avoidance_active_out && !$past(avoidance_active_out) && !$past(avoidance_active_out, 3)
      && $past(rst_n_in, 3) && $stable(base_freq_in) && base_freq_in <= 16'h0fa0 |-> out_freq_out == base_freq_in;
   endproperty
   a_idle_freq: assert property (p_idle_freq) else $error("idle output differs from base");
   c_start: cover property ($rose(avoidance_active_out));
   c_stall: cover property ($rose(stall_output_signal_out));
   c_irq: cover property ($rose(irq_out));
endmodule // rac_monitor

bind rac_core rac_monitor mon_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .bus_voltage_in(bus_voltage_in), .base_freq_in(base_freq_in),
   .out_freq_out(out_freq_out), .avoidance_active_out(avoidance_active_out),
   .overvoltage_stall_indication_out(overvoltage_stall_indication_out),
   .stall_prevention_out(stall_prevention_out), .stall_output_signal_out(stall_output_signal_out),
   .irq_out(irq_out));

// File: verification/rac_core_tb.sv
// self-checking testbench of the regeneration avoidance block
`include "rac_params.svh"
module rac_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, accel_cmd, decel_cmd, accel, decel;
   logic active, indic, prev, stall, irq;
   logic [3:0] reg_addr_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, bus_cmd, base_cmd, bus_v, base_f, out_f, rd_val;
   int error_cnt, n_compared;
   rac_drive_model drv_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_cmd_in(bus_cmd),
      .base_cmd_in(base_cmd), .accel_cmd_in(accel_cmd), .decel_cmd_in(decel_cmd), .bus_voltage_out(bus_v),
      .base_freq_out(base_f), .accel_out(accel), .decel_out(decel));
   rac_core #(.TICK(4)) dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .bus_voltage_in(bus_v), .base_freq_in(base_f), .accel_in(accel), .decel_in(decel), .out_freq_out(out_f),
      .avoidance_active_out(active), .overvoltage_stall_indication_out(indic), .stall_prevention_out(prev),
      .stall_output_signal_out(stall), .irq_out(irq));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      rd_val = reg_rdata_out;
   endtask
   task automatic drive(input logic [15:0] bus, input logic [15:0] base, input logic acc, input logic dec);
      @(posedge core_clk_in);
      bus_cmd <= bus;
      base_cmd <= base;
      accel_cmd <= acc;
      decel_cmd <= dec;
   endtask
   // slow withdrawal: compensation may be thousands of steps deep
   task automatic settle();
      drive(16'h012c, base_cmd, 1'b0, 1'b0);
      for (int i = 0; i < 20000 && active !== 1'b0; i++) cyc(1);
      cyc(4);
      chk({15'h0, active}, 16'h0000);
      chk(out_f, base_cmd);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [15:0] exp [6] = '{16'h0000, 16'h0190, 16'h0258, 16'h0064, 16'h0064, 16'h2710};
      for (int i = 0; i < 6; i++)
      begin
         rd((i == 5) ? `RAC_OFF_MAX_FREQ : 4'(i));
         chk(rd_val, exp[i]);
      end
      rd(4'hd);
      chk(rd_val, 16'h0000);
   endtask
   task automatic t_lock();
      wr(`RAC_OFF_DISP_SEL, 16'h0001);
      wr(`RAC_OFF_MODE, `RAC_MODE_ALWAYS);
      rd(`RAC_OFF_MODE);
      chk(rd_val, `RAC_MODE_OFF);
      wr(`RAC_OFF_DISP_SEL, 16'h0000);
      wr(`RAC_OFF_MODE, `RAC_MODE_ALWAYS);
      rd(`RAC_OFF_MODE);
      chk(rd_val, `RAC_MODE_ALWAYS);
      wr(`RAC_OFF_MODE, 16'h0003);
      rd(`RAC_OFF_MODE);
      chk(rd_val, `RAC_MODE_ALWAYS);
      wr(`RAC_OFF_LEVEL, 16'h0384);
      rd(`RAC_OFF_LEVEL);
      chk(rd_val, `RAC_LEVEL_MAX);
      wr(`RAC_OFF_LEVEL, `RAC_LEVEL_RST_LOW);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 3; m++)
      begin
         // mode first: a bus rise under the old mode would latch avoidance on
         wr(`RAC_OFF_MODE, 16'(m));
         drive(16'h01c2, 16'h03e8, 1'b1, 1'b0);
         cyc(20);
         chk({15'h0, active}, (m == 1) ? 16'h0001 : 16'h0000);
         settle();
      end
      drive(16'h01c2, 16'h03e8, 1'b0, 1'b0);
      cyc(20);
      chk({15'h0, active}, 16'h0001);
      chk({15'h0, stall}, 16'h0000);
      settle();
   endtask
   task automatic t_gain();
      wr(`RAC_OFF_MODE, `RAC_MODE_ALWAYS);
      wr(`RAC_OFF_VGAIN, 16'h0000);
      wr(`RAC_OFF_FGAIN, 16'h0000);
      drive(16'h0320, 16'h03e8, 1'b0, 1'b0);
      cyc(10);
      chk({15'h0, out_f < 16'h0408}, 16'h0001);
      wr(`RAC_OFF_VGAIN, `RAC_GAIN_RST);
      wr(`RAC_OFF_FGAIN, `RAC_GAIN_RST);
      settle();
   endtask
   task automatic t_limit();
      wr(`RAC_OFF_STALL_SEL, 16'h0001);
      wr(`RAC_OFF_IRQ_STATUS, 16'h0007);
      wr(`RAC_OFF_IRQ_MASK, 16'h0007);
      wr(`RAC_OFF_STALL_TMR, 16'h0002);
      drive(16'h0320, 16'h03e8, 1'b0, 1'b0);
      cyc(4);
      chk({15'h0, stall}, 16'h0000);
      cyc(46);
      chk(out_f, 16'h0640);
      chk({12'h0, indic, prev, stall, active}, 16'h000f);
      chk({15'h0, irq}, 16'h0001);
      wr(`RAC_OFF_LIMIT, `RAC_LIMIT_NONE);
      cyc(400);
      chk(out_f, 16'h2710);
      rd(`RAC_OFF_IRQ_STATUS);
      chk(rd_val, 16'h0005);
      wr(`RAC_OFF_IRQ_STATUS, 16'h0007);
      cyc(1);
      chk({15'h0, irq}, 16'h0000);
      settle();
      rd(`RAC_OFF_IRQ_STATUS);
      chk(rd_val, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      wr(`RAC_OFF_IRQ_STATUS, 16'h0007);
      wr(`RAC_OFF_IRQ_MASK, 16'h0000);
      wr(`RAC_OFF_LIMIT, `RAC_LIMIT_RST);
   endtask
   task automatic t_decel();
      drive(16'h0320, 16'h0fa0, 1'b0, 1'b1);
      cyc(50);
      chk(out_f, 16'h11f8);
      drive(16'h0320, 16'h0bb8, 1'b0, 1'b1);
      cyc(5);
      chk(out_f, 16'h0e10);
      // bus back to normal: limit still held while decelerating
      drive(16'h012c, 16'h0bb8, 1'b0, 1'b1);
      cyc(5);
      chk(out_f, 16'h0e10);
      drive(16'h012c, 16'h0064, 1'b0, 1'b1);
      cyc(5);
      chk({15'h0, out_f < 16'h02bc}, 16'h0001);
      settle();
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      repeat (60000) @(posedge core_clk_in);
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      {rst_n_in, reg_wr_in, reg_rd_in, accel_cmd, decel_cmd} = 5'h00;
      {reg_addr_in, reg_wdata_in} = 20'h00000;
      bus_cmd = 16'h012c;
      base_cmd = 16'h03e8;
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_lock();
      t_modes();
      t_gain();
      t_limit();
      t_decel();
      give_verdict();
   end
endmodule // rac_core_tb
